// ==== rtl/spmsp_pkg.sv ====
package spmsp_pkg;

  localparam int unsigned SFR_AW = 8;
  localparam int unsigned SFR_DW = 8;

  // register addresses on the core's register port
  localparam logic [SFR_AW-1:0] ADDR_DATA = 8'hF7;
  localparam logic [SFR_AW-1:0] ADDR_CTRL = 8'hF8;

  // reset values
  localparam logic [SFR_DW-1:0] DATA_RST = 8'h00;
  localparam logic [SFR_DW-1:0] CTRL_RST = 8'h00;

  // control register field positions
  localparam int unsigned CTL_DONE   = 7;
  localparam int unsigned CTL_WRITE_COLLISION_FLAG   = 6;
  localparam int unsigned CTL_PSEL   = 5;
  localparam int unsigned CTL_MSTR   = 4;
  localparam int unsigned CTL_CLOCK_IDLE_LEVEL   = 3;
  localparam int unsigned CTL_CLOCK_PHASE   = 2;
  localparam int unsigned CTL_RATE_H = 1;
  localparam int unsigned CTL_RATE_L = 0;

  // bits per byte and bit counter width
  localparam int unsigned CNT_W          = 4;
  localparam logic [CNT_W-1:0] BIT_LAST  = 4'h7;
  localparam logic [CNT_W-1:0] BIT_FULL  = 4'h8;

  // half serial clock period is (1 << rate) core cycles: /2, /4, /8, /16
  localparam int unsigned HALF_W         = 3;
  localparam logic [3:0]  HALF_BASE      = 4'h1;

  // synchroniser input lanes
  localparam int unsigned SYN_SCLK = 0;
  localparam int unsigned SYN_MOSI = 1;
  localparam int unsigned SYN_MISO = 2;
  localparam int unsigned SYN_SSN  = 3;
  localparam int unsigned SYN_W    = 4;

  typedef enum logic {
    MS_IDLE = 1'b0,
    MS_RUN  = 1'b1
  } spmsp_mst_e;

endpackage

// ==== rtl/spmsp_port.sv ====
`timescale 1ns/100ps
module spmsp_port (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst,
  input  wire logic [spmsp_pkg::SFR_AW-1:0]  i_sfr_addr,
  input  wire logic                          i_sfr_wr,
  input  wire logic                          i_sfr_rd,
  input  wire logic [spmsp_pkg::SFR_DW-1:0]  i_sfr_wdata,
  output logic      [spmsp_pkg::SFR_DW-1:0]  o_sfr_rdata,
  input  wire logic                          i_sclk,
  output logic                               o_sclk,
  output logic                               o_sclk_oe_n,
  input  wire logic                          i_mosi,
  output logic                               o_mosi,
  output logic                               o_mosi_oe_n,
  input  wire logic                          i_miso,
  output logic                               o_miso,
  output logic                               o_miso_oe_n,
  input  wire logic                          i_ss_n,
  output logic                               o_port_select,
  output logic                               o_xfer_done_flag
);
  import spmsp_pkg::*;

  logic [SYN_W-1:0]  sync1_q;
  logic [SYN_W-1:0]  sync2_q;
  logic              sclk_prev_q;
  logic              ss_n_prev_q;

  logic              done_q;
  logic              write_collision_flag_q;
  logic              psel_q;
  logic              mstr_q;
  logic              clock_idle_level_q;
  logic              clock_phase_q;
  logic [1:0]        rate_q;

  spmsp_mst_e        st_q;
  logic [HALF_W-1:0] half_q;
  logic              sclk_q;
  logic [CNT_W-1:0]  bit_q;
  logic [7:0]        sh_q;
  logic              held_q;
  logic              out_q;
  logic [7:0]        rx_q;

  logic              wr_dat;
  logic              wr_ctl;
  logic              rd_dat;
  logic              ss_low;
  logic              slv_act;
  logic              s_edge;
  logic              m_tick;
  logic              lead;
  logic              trail;
  logic              in_bit;
  logic              busy;
  logic              end_cnt;
  logic              end_ss;
  logic              byte_end;
  logic [7:0]        trail_sh;
  logic [HALF_W-1:0] half_reload;

  assign wr_dat = i_sfr_wr && (i_sfr_addr == ADDR_DATA);
  assign wr_ctl = i_sfr_wr && (i_sfr_addr == ADDR_CTRL);
  assign rd_dat = i_sfr_rd && (i_sfr_addr == ADDR_DATA);

  // two-stage synchronisers for every pin input
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end else begin
      sync1_q <= {i_ss_n, i_miso, i_mosi, i_sclk};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sclk_prev_q <= 1'b1;
      ss_n_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sync2_q[SYN_SCLK];
      ss_n_prev_q <= sync2_q[SYN_SSN];
    end
  end

  assign ss_low  = !sync2_q[SYN_SSN];
  assign slv_act = psel_q && !mstr_q && ss_low;
  assign s_edge  = slv_act && (sync2_q[SYN_SCLK] != sclk_prev_q);

  assign half_reload = HALF_W'((HALF_BASE << rate_q) - HALF_BASE);
  assign m_tick      = (st_q == MS_RUN) && (half_q == '0);

  // leading edge leaves the idle level, trailing edge returns to it
  always_comb begin
    if (mstr_q) begin
      lead   = m_tick && (sclk_q == clock_idle_level_q);
      trail  = m_tick && (sclk_q != clock_idle_level_q);
      in_bit = sync2_q[SYN_MISO];
    end else begin
      lead   = s_edge && (sclk_prev_q == clock_idle_level_q);
      trail  = s_edge && (sclk_prev_q != clock_idle_level_q);
      in_bit = sync2_q[SYN_MOSI];
    end
  end

  // phase 1 samples on trailing edge, phase 0 uses bit held from leading edge
  assign trail_sh = {sh_q[6:0], clock_phase_q ? in_bit : held_q};

  assign busy    = (st_q == MS_RUN) || (!mstr_q && (bit_q != '0));
  assign end_cnt = trail && (bit_q == BIT_LAST) && (mstr_q || clock_phase_q);
  assign end_ss  = !mstr_q && !clock_phase_q && psel_q && sync2_q[SYN_SSN] && !ss_n_prev_q
                   && (bit_q != '0);
  assign byte_end = end_cnt || end_ss;

  // control register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      psel_q <= CTRL_RST[CTL_PSEL];
      mstr_q <= CTRL_RST[CTL_MSTR];
      clock_idle_level_q <= CTRL_RST[CTL_CLOCK_IDLE_LEVEL];
      clock_phase_q <= CTRL_RST[CTL_CLOCK_PHASE];
      rate_q <= CTRL_RST[CTL_RATE_H:CTL_RATE_L];
    end else if (wr_ctl) begin
      psel_q <= i_sfr_wdata[CTL_PSEL];
      mstr_q <= i_sfr_wdata[CTL_MSTR];
      clock_idle_level_q <= i_sfr_wdata[CTL_CLOCK_IDLE_LEVEL];
      clock_phase_q <= i_sfr_wdata[CTL_CLOCK_PHASE];
      rate_q <= i_sfr_wdata[CTL_RATE_H:CTL_RATE_L];
    end
  end

  // transfer-done flag, hardware set wins over any clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      done_q <= CTRL_RST[CTL_DONE];
    end else if (byte_end) begin
      done_q <= 1'b1;
    end else if (wr_ctl) begin
      done_q <= i_sfr_wdata[CTL_DONE];
    end else if (rd_dat) begin
      done_q <= 1'b0;
    end
  end

  // write-collision flag, only software clears
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      write_collision_flag_q <= CTRL_RST[CTL_WRITE_COLLISION_FLAG];
    end else if (wr_dat && busy) begin
      write_collision_flag_q <= 1'b1;
    end else if (wr_ctl) begin
      write_collision_flag_q <= i_sfr_wdata[CTL_WRITE_COLLISION_FLAG];
    end
  end

  // master clock generator
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_q   <= MS_IDLE;
      half_q <= '0;
      sclk_q <= 1'b0;
    end else begin
      unique case (st_q)
        MS_IDLE: begin
          sclk_q <= clock_idle_level_q;
          half_q <= half_reload;
          if (wr_dat && psel_q && mstr_q) begin
            st_q <= MS_RUN;
          end
        end
        MS_RUN: begin
          if (m_tick) begin
            sclk_q <= !sclk_q;
            half_q <= half_reload;
            if (end_cnt) begin
              st_q <= MS_IDLE;
            end
          end else begin
            half_q <= half_q - HALF_W'(1);
          end
        end
      endcase
    end
  end

  // bit counter
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bit_q <= '0;
    end else if (byte_end) begin
      bit_q <= '0;
    end else if (!mstr_q && !ss_low) begin
      bit_q <= '0;
    end else if (trail && (bit_q != BIT_FULL)) begin
      bit_q <= bit_q + CNT_W'(1);
    end
  end

  // shift register, loaded only when idle so a colliding write is dropped
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sh_q <= DATA_RST;
    end else if (wr_dat && !busy) begin
      sh_q <= i_sfr_wdata;
    end else if (trail) begin
      sh_q <= trail_sh;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      held_q <= 1'b0;
    end else if (lead) begin
      held_q <= in_bit;
    end
  end

  // outgoing bit: phase 0 presents it ahead of the leading edge
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      out_q <= 1'b0;
    end else if (!clock_phase_q) begin
      // follow the shift register's next value so the bit leads the clock
      if (wr_dat && !busy) begin
        out_q <= i_sfr_wdata[7];
      end else if (trail) begin
        out_q <= trail_sh[7];
      end else begin
        out_q <= sh_q[7];
      end
    end else if (lead) begin
      out_q <= sh_q[7];
    end
  end

  // received byte
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_q <= DATA_RST;
    end else if (end_cnt) begin
      rx_q <= trail_sh;
    end else if (end_ss) begin
      rx_q <= sh_q;
    end
  end

  // register read port, one cycle latency
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sfr_rdata <= '0;
    end else begin
      unique case (i_sfr_addr)
        ADDR_DATA: o_sfr_rdata <= rx_q;
        ADDR_CTRL: o_sfr_rdata <= {done_q, write_collision_flag_q, psel_q, mstr_q, clock_idle_level_q, clock_phase_q,
                                   rate_q[1], mstr_q ? rate_q[0] : sync2_q[SYN_SSN]};
        default:   o_sfr_rdata <= '0;
      endcase
    end
  end

  // pin drivers; enables active low
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sclk        <= 1'b0;
      o_sclk_oe_n   <= 1'b1;
      o_mosi        <= 1'b0;
      o_mosi_oe_n   <= 1'b1;
      o_miso        <= 1'b0;
      o_miso_oe_n   <= 1'b1;
      o_port_select <= 1'b0;
    end else begin
      o_sclk        <= sclk_q;
      o_sclk_oe_n   <= !(psel_q && mstr_q);
      o_mosi        <= out_q;
      o_mosi_oe_n   <= !(psel_q && mstr_q);
      o_miso        <= out_q;
      o_miso_oe_n   <= !slv_act;
      o_port_select <= psel_q;
    end
  end

  assign o_xfer_done_flag = done_q;

endmodule // spmsp_port

// ==== tb/spmsp_port_monitor.sv ====
`timescale 1ns/100ps
module spmsp_port_monitor
  import spmsp_pkg::*;
(
  input wire logic       i_clk_sys,
  input wire logic       i_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       i_ss_n,
  input wire logic       o_sclk,
  input wire logic       o_sclk_oe_n,
  input wire logic       o_miso_oe_n,
  input wire logic       o_port_select,
  input wire logic       o_xfer_done_flag
);
  logic [7:0] ctl_q;
  logic       sclk_q;
  logic [5:0] gap_q;
  logic [5:0] half_m1;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  assign half_m1 = (6'h01 << ctl_q[1:0]) - 6'h01;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) ctl_q <= CTRL_RST;
    else if (i_sfr_wr && i_sfr_addr == ADDR_CTRL) ctl_q <= i_sfr_wdata;
  end
  // cycles since the last serial clock change, saturating
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sclk_q <= 1'b0;
      gap_q  <= 6'h3F;
    end else begin
      sclk_q <= o_sclk;
      gap_q  <= (o_sclk != sclk_q) ? 6'h00 : gap_q + 6'(gap_q != 6'h3F);
    end
  end
  chk_sclk_half: assert property (!o_sclk_oe_n && o_sclk != sclk_q
    && gap_q < 6'(2 * half_m1 + 2) |-> gap_q == half_m1) else $error("serial clock half period wrong");
  chk_pin_owner: assert property (!(!o_sclk_oe_n && !o_miso_oe_n))
    else $error("clock and slave data driven together");
  chk_miso_select: assert property ($fell(o_miso_oe_n)
    |-> !$past(i_ss_n, 2) || !$past(i_ss_n, 3) || !$past(i_ss_n, 4)) else $error("slave drives unselected");
  chk_miso_release: assert property ($rose(i_ss_n) |-> ##[2:4] o_miso_oe_n)
    else $error("slave data not released");
  chk_psel_write: assert property ($rose(o_port_select) |-> $past(i_sfr_wr) || $past(i_sfr_wr, 2))
    else $error("port select changed without write");
  chk_done_rdclr: assert property (i_sfr_rd && i_sfr_addr == ADDR_DATA && o_xfer_done_flag
    |=> !o_xfer_done_flag) else $error("data read did not clear done");
  chk_done_hold: assert property (o_xfer_done_flag && !i_sfr_wr && !i_sfr_rd |=> o_xfer_done_flag)
    else $error("done flag dropped by itself");
  chk_ctrl_done: assert property (i_sfr_addr == ADDR_CTRL
    |=> o_sfr_rdata[CTL_DONE] == $past(o_xfer_done_flag)) else $error("control read done bit wrong");
  chk_unmapped: assert property (i_sfr_addr != ADDR_DATA && i_sfr_addr != ADDR_CTRL
    |=> o_sfr_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // spmsp_port_monitor

bind spmsp_port spmsp_port_monitor u_mon (.i_clk_sys, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
  .i_sfr_wdata, .o_sfr_rdata, .i_ss_n, .o_sclk, .o_sclk_oe_n, .o_miso_oe_n, .o_port_select,
  .o_xfer_done_flag);

// ==== tb/spmsp_slave_model.sv ====
`timescale 1ns/100ps
module spmsp_slave_model (
  input  wire logic       i_sclk,
  input  wire logic       i_mosi,
  input  wire logic       i_clock_idle_level,
  input  wire logic       i_clock_phase,
  input  wire logic       i_load,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic      [7:0] o_rx
);
  logic [7:0] sh_q;
  // any toggle of i_load starts a fresh byte
  always @(i_load) begin
    sh_q = i_tx;
    o_rx = 8'h00;
    o_miso = i_tx[7];
  end
  always @(i_sclk) begin
    if ((i_sclk ^ i_clock_idle_level) != i_clock_phase) o_rx = {o_rx[6:0], i_mosi};
    else if (i_clock_phase) begin
      o_miso = sh_q[7];
      sh_q = sh_q << 1;
    end else begin
      sh_q = sh_q << 1;
      o_miso = sh_q[7];
    end
  end
endmodule // spmsp_slave_model

// ==== tb/spmsp_port_bench.sv ====
`timescale 1ns/100ps
module spmsp_port_bench;
  import spmsp_pkg::*;
  logic        clk, rst, wr, rd, sclk_tb, mosi_tb, ss_n, ld, clock_idle_level, clock_phase;
  logic [7:0]  addr, wd, rdv, mr, stx;
  logic [31:0] seed;
  wire  [7:0]  rdata, mrx;
  wire         sclk_w, mosi_w, miso_w, m_miso, psel, done;
  wire         o_sclk, o_sclk_oe_n, o_mosi, o_mosi_oe_n, o_miso, o_miso_oe_n;
  int          failures, comparisons, tog;
  assign sclk_w = o_sclk_oe_n ? sclk_tb : o_sclk;
  assign mosi_w = o_mosi_oe_n ? mosi_tb : o_mosi;
  assign miso_w = o_miso_oe_n ? m_miso : o_miso;
  spmsp_port DUT (.i_clk_sys(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wd), .o_sfr_rdata(rdata), .i_sclk(sclk_w), .o_sclk, .o_sclk_oe_n, .i_mosi(mosi_w),
    .o_mosi, .o_mosi_oe_n, .i_miso(miso_w), .o_miso, .o_miso_oe_n, .i_ss_n(ss_n),
    .o_port_select(psel), .o_xfer_done_flag(done));
  spmsp_slave_model u_slave (.i_sclk(sclk_w), .i_mosi(mosi_w), .i_clock_idle_level(clock_idle_level), .i_clock_phase(clock_phase),
    .i_load(ld), .i_tx(stx), .o_miso(m_miso), .o_rx(mrx));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(sclk_w) tog++;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] g, logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrt(logic [7:0] a, logic [7:0] d);
    @(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rdt(logic [7:0] a);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 rdv = rdata;
  endtask
  task automatic mx(logic [7:0] c, logic wc);
    logic [7:0] t, e;
    seed = lfsr(seed);
    {stx, t} = seed[15:0];
    {clock_idle_level, clock_phase} = c[3:2];
    e = c | {1'b0, wc, 6'h00};
    wrt(ADDR_CTRL, c);
    repeat (20) @(posedge clk);
    ld = ~ld;
    tog = 0;
    wrt(ADDR_DATA, t);
    if (wc) wrt(ADDR_DATA, ~t);
    for (int i = 0; i < 600 && done !== 1'b1; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk("pins", {6'h00, psel, o_sclk_oe_n}, 8'h02);
    chk("sclk toggles", 8'(tog), 8'h10);
    chk("mosi byte", mrx, t);
    rdt(ADDR_CTRL);
    chk("ctrl after byte", rdv, e | 8'h80);
    rdt(ADDR_DATA);
    if (c[1:0] == 2'h3) chk("miso byte", rdv, stx);
    rdt(ADDR_CTRL);
    chk("ctrl after read", rdv, e);
    $display("master test ctrl %h done", c);
  endtask
  task automatic sl(logic [7:0] b, logic ph);
    seed = lfsr(seed);
    stx = seed[7:0];
    mr = 8'h00;
    wrt(ADDR_CTRL, 8'h20 | {5'h00, ph, 2'h0});
    wrt(ADDR_DATA, stx);
    rdt(ADDR_CTRL);
    chk("ss high", rdv, 8'h21 | {5'h00, ph, 2'h0});
    @(posedge clk) ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) {mosi_tb, sclk_tb} <= {b[i], ph};
      repeat (7) @(posedge clk);
      mr = {mr[6:0], miso_w};
      sclk_tb <= !ph;
      repeat (7) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    sclk_tb <= 1'b0;
    repeat (8) @(posedge clk);
    rdt(ADDR_CTRL);
    chk("ss low", rdv, {ph, 2'h1, 2'h0, ph, 2'h0});
    @(posedge clk) ss_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("slave done", {7'h00, done}, 8'h01);
    rdt(ADDR_DATA);
    chk("slave rx", rdv, b);
    chk("slave tx", mr, stx);
    $display("slave test done");
  endtask
  // budget well above the longest transfer sequence
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish;
  end
  initial begin
    {rst, wr, rd, addr, wd, sclk_tb, mosi_tb, ss_n, ld, clock_idle_level, clock_phase} = {3'h4, 16'h0000, 6'h08};
    seed = 32'hF08A;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdt(ADDR_DATA);
    chk("data reset", rdv, DATA_RST);
    rdt(ADDR_CTRL);
    chk("ctrl reset", rdv, CTRL_RST | 8'h01);
    rdt(8'h10);
    chk("unmapped", rdv, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 16; k++) mx(8'h30 | 8'(k), k == 7);
    wrt(ADDR_CTRL, 8'h10);
    repeat (3) @(posedge clk);
    chk("pins to other port", {6'h00, psel, o_sclk_oe_n}, 8'h01);
    sl(seed[15:8], 1'b0);
    sl(seed[23:16], 1'b1);
    tally_and_finish;
  end
endmodule // spmsp_port_bench
